// ==== src/sector_erase_host.sv ====
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "flash_host_map.svh"

// Functional notes
// - sector erase is six writes: unlock, setup, unlock, sector address with 30
// - unlock writes AA to 555, then 55 to 2AA; setup writes 80 to 555
// - host spaces extra sector writes under 40 us apart
// - hardware reset aborts erase; host sets the rerun flag and software reruns the sequence
// - resume is 30 to the suspended sector; repeats are refused and set the refused flag
module sector_erase_host
  import flash_host_pkg::*;
#(
  parameter int WINDOW_CYCLES    = `WINDOW_US * `CLK_MHZ,
  parameter int ADD_LIMIT_CYCLES = `ADD_LIMIT_US * `CLK_MHZ,
  parameter int SUSPEND_CYCLES   = `SUSPEND_US * `CLK_MHZ,
  parameter int RST_LOW_CYCLES   = (`RST_LOW_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int RST_REC_CYCLES   = (`RST_REC_NS + `CLK_NS - 1) / `CLK_NS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [20:0]      flash_addr_out,
  output logic [15:0]      flash_dq_out,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_dq_oe_b_out,
  output logic             flash_ce_b_out,
  output logic             flash_we_b_out,
  output logic             flash_oe_b_out,
  output logic             flash_reset_b_out
);

  if (ADD_LIMIT_CYCLES < 1 || ADD_LIMIT_CYCLES >= WINDOW_CYCLES || WINDOW_CYCLES > 65535 ||
      SUSPEND_CYCLES < 1 || SUSPEND_CYCLES > 65535 || RST_LOW_CYCLES < 1 ||
      RST_LOW_CYCLES > 65535 || RST_REC_CYCLES < 1 || RST_REC_CYCLES > 65535) begin : g_chk
    $error("sector_erase_host: timing parameters out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  seq_state_t  state;
  op_t         op;
  logic [2:0]  step;
  logic [15:0] tcnt;
  logic [15:0] win_cnt;
  logic [5:0]  sector;
  logic [5:0]  susp_sector;
  logic [20:0] rd_addr;
  logic [15:0] wdata;
  logic        window_open;
  logic        erasing;
  logic        suspended;
  logic        refused;
  logic        rerun;
  logic        cyc_req;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic [36:0] word;
  logic        last_step;
  logic        seq_done;
  logic        apb_wr;
  logic        apb_rd;
  logic        cmd_wr;
  logic        accept;
  logic        mapped;

  // ----------------------------------------------------------------
  // command tables
  // ----------------------------------------------------------------
  // address and data of one step of a sequence
  function automatic logic [36:0] step_word(input op_t o, input logic [2:0] i,
                                            input logic [5:0] sec, input logic [20:0] a,
                                            input logic [15:0] d);
    logic [20:0] sec_base;
    sec_base = {sec, 15'h0000};
    step_word = {a, 16'h0000};
    unique case (o)
      `OP_ERASE: unique case (i)
        3'd0, 3'd3: step_word = {`UNLOCK_A1, `UNLOCK_D1};
        3'd1, 3'd4: step_word = {`UNLOCK_A2, `UNLOCK_D2};
        3'd2:       step_word = {`UNLOCK_A1, `CODE_SETUP};
        default:    step_word = {sec_base, `CODE_SECTOR};
      endcase
      `OP_ADD:      step_word = {sec_base, `CODE_SECTOR};
      `OP_SUSPEND:  step_word = {sec_base, `CODE_SUSPEND};
      `OP_RESUME:   step_word = {{susp_sector, 15'h0000}, `CODE_RESUME};
      `OP_SOFT_RST: step_word = {a, `CODE_RESET};
      `OP_PROGRAM, `OP_AUTOSEL: unique case (i)
        3'd0:    step_word = {`UNLOCK_A1, `UNLOCK_D1};
        3'd1:    step_word = {`UNLOCK_A2, `UNLOCK_D2};
        3'd2:    step_word = {`UNLOCK_A1, (o == `OP_PROGRAM) ? `CODE_PROGRAM : `CODE_AUTOSEL};
        default: step_word = {a, d};
      endcase
      default: step_word = {a, 16'h0000};
    endcase
  endfunction : step_word

  // number of bus cycles of each operation
  function automatic logic [2:0] seq_len(input op_t o);
    unique case (o)
      `OP_ERASE:   seq_len = 3'd6;
      `OP_PROGRAM: seq_len = 3'd4;
      `OP_AUTOSEL: seq_len = 3'd3;
      default:     seq_len = 3'd1;
    endcase
  endfunction : seq_len

  // whether an operation may start in the present erase state
  function automatic logic op_allowed(input op_t o, input logic er, input logic win,
                                      input logic sus, input logic [15:0] wtime);
    unique case (o)
      `OP_ERASE:   op_allowed = !er;
      `OP_ADD:     op_allowed = win && wtime < 16'(ADD_LIMIT_CYCLES);
      `OP_SUSPEND: op_allowed = er && !sus;
      `OP_RESUME:  op_allowed = sus;
      `OP_READ, `OP_HW_RST: op_allowed = 1'b1;
      `OP_PROGRAM, `OP_AUTOSEL, `OP_SOFT_RST:
                   op_allowed = !er || win || sus;
      `OP_DONE:    op_allowed = er && !win && !sus;
      default:     op_allowed = 1'b0;
    endcase
  endfunction : op_allowed

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign pready_out = 1'b1;
  assign apb_wr     = psel_in && penable_in && pwrite_in;
  assign apb_rd     = psel_in && penable_in && !pwrite_in;
  assign mapped     = paddr_in == `REG_CMD || paddr_in == `REG_SECTOR ||
                      paddr_in == `REG_ADDR || paddr_in == `REG_WDATA ||
                      paddr_in == `REG_STATUS || paddr_in == `REG_RDATA;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign cmd_wr     = apb_wr && paddr_in == `REG_CMD;
  assign accept     = cmd_wr && state == SEQ_IDLE &&
                      op_allowed(op_t'(pwdata_in[3:0]), erasing, window_open, suspended, win_cnt);

  // software parameter registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sector  <= `SECTOR_RESET;
      rd_addr <= `ADDR_RESET;
      wdata   <= `WDATA_RESET;
    end else if (apb_wr) begin
      if (paddr_in == `REG_SECTOR) sector  <= pwdata_in[5:0];
      if (paddr_in == `REG_ADDR)   rd_addr <= pwdata_in[20:0];
      if (paddr_in == `REG_WDATA)  wdata   <= pwdata_in[15:0];
    end
  end

  // read mux, registered so data stands for the access phase
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) prdata_out <= 32'h0000_0000;
    else if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        `REG_CMD:    prdata_out <= {28'h000_0000, op};
        `REG_SECTOR: prdata_out <= {26'h000_0000, sector};
        `REG_ADDR:   prdata_out <= {11'h000, rd_addr};
        `REG_WDATA:  prdata_out <= {16'h0000, wdata};
        `REG_STATUS: prdata_out <= {26'h000_0000, rerun, refused, suspended, erasing,
                                    window_open, state != SEQ_IDLE};
        `REG_RDATA:  prdata_out <= {16'h0000, cyc_rdata};
        default:     prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // sticky flags: hardware set wins over write-one clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      refused <= 1'b0;
      rerun   <= 1'b0;
    end else begin
      if (cmd_wr && !accept) refused <= 1'b1;
      else if (apb_wr && paddr_in == `REG_STATUS && pwdata_in[`ST_REFUSED]) refused <= 1'b0;
      if (state == SEQ_RST_LOW && erasing) rerun <= 1'b1;
      else if (accept && pwdata_in[3:0] == `OP_ERASE) rerun <= 1'b0;
      else if (apb_wr && paddr_in == `REG_STATUS && pwdata_in[`ST_RERUN]) rerun <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign word      = step_word(op, step, sector, rd_addr, wdata);
  assign last_step = step == seq_len(op) - 3'd1;
  assign seq_done  = state == SEQ_ISSUE && cyc_done && last_step;
  assign cyc_req   = state == SEQ_ISSUE && !cyc_done;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= SEQ_IDLE;
      op    <= 4'h0;
      step  <= 3'd0;
      tcnt  <= 16'h0000;
    end else begin
      unique case (state)
        SEQ_IDLE: if (accept) begin
          op   <= op_t'(pwdata_in[3:0]);
          step <= 3'd0;
          if (pwdata_in[3:0] == `OP_HW_RST) begin
            state <= SEQ_RST_LOW;
            tcnt  <= 16'(RST_LOW_CYCLES - 1);
          end else if (pwdata_in[3:0] != `OP_DONE) state <= SEQ_ISSUE;
        end
        SEQ_ISSUE: if (cyc_done) begin
          if (!last_step) step <= step + 3'd1;
          else if (op == `OP_SUSPEND && !window_open) begin
            state <= SEQ_SUSP_WAIT;
            tcnt  <= 16'(SUSPEND_CYCLES - 1);
          end else state <= SEQ_IDLE;
        end
        SEQ_SUSP_WAIT: if (tcnt == 16'h0000) state <= SEQ_IDLE;
          else tcnt <= tcnt - 16'h0001;
        SEQ_RST_LOW: if (tcnt == 16'h0000) begin
          state <= SEQ_RST_REC;
          tcnt  <= 16'(RST_REC_CYCLES - 1);
        end else tcnt <= tcnt - 16'h0001;
        SEQ_RST_REC: if (tcnt == 16'h0000) state <= SEQ_IDLE;
          else tcnt <= tcnt - 16'h0001;
      endcase
    end
  end

  // device reset pin
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) flash_reset_b_out <= 1'b1;
    else flash_reset_b_out <= !(state == SEQ_IDLE ? (accept && pwdata_in[3:0] == `OP_HW_RST)
                                                  : state == SEQ_RST_LOW && tcnt != 16'h0000);
  end

  // ----------------------------------------------------------------
  // erase state tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      erasing     <= 1'b0;
      window_open <= 1'b0;
      suspended   <= 1'b0;
      susp_sector <= 6'h00;
    end else if (state == SEQ_RST_LOW) begin
      erasing     <= 1'b0;
      window_open <= 1'b0;
      suspended   <= 1'b0;
    end else if (accept && pwdata_in[3:0] == `OP_DONE) begin
      erasing     <= 1'b0;
    end else if (seq_done) begin
      unique case (op)
        `OP_ERASE: begin
          erasing     <= 1'b1;
          window_open <= 1'b1;
          susp_sector <= sector;
        end
        `OP_SUSPEND: if (window_open) begin
          window_open <= 1'b0;
          suspended   <= 1'b1;
        end
        `OP_RESUME: suspended <= 1'b0;
        `OP_PROGRAM, `OP_AUTOSEL, `OP_SOFT_RST: if (window_open) begin
          window_open <= 1'b0;
          erasing     <= 1'b0;
        end else if (op == `OP_SOFT_RST && !suspended) erasing <= 1'b0;
        default: ;
      endcase
    end else if (state == SEQ_SUSP_WAIT && tcnt == 16'h0000) begin
      suspended <= 1'b1;
    end else if (window_open && win_cnt == 16'(WINDOW_CYCLES - 1)) begin
      window_open <= 1'b0;
    end
  end

  // window timer restarts after each sector write strobe rises
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) win_cnt <= 16'h0000;
    else if (seq_done && (op == `OP_ERASE || op == `OP_ADD)) win_cnt <= 16'h0000;
    else if (window_open && win_cnt != 16'hFFFF) win_cnt <= win_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // bus cycle engine
  // ----------------------------------------------------------------
  flash_bus_cycle u_cycle (
    .clk_in            (clk_in),
    .rst_b_in          (rst_b_in),
    .req_in            (cyc_req),
    .wr_in             (op != `OP_READ),
    .addr_in           (word[36:16]),
    .wdata_in          (word[15:0]),
    .done_out          (cyc_done),
    .rdata_out         (cyc_rdata),
    .flash_addr_out    (flash_addr_out),
    .flash_dq_out      (flash_dq_out),
    .flash_dq_in       (flash_dq_in),
    .flash_dq_oe_b_out (flash_dq_oe_b_out),
    .flash_ce_b_out    (flash_ce_b_out),
    .flash_we_b_out    (flash_we_b_out),
    .flash_oe_b_out    (flash_oe_b_out)
  );

endmodule : sector_erase_host

// ==== src/flash_host_map.svh ====
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define REG_CMD       8'h00
`define REG_SECTOR    8'h04
`define REG_ADDR      8'h08
`define REG_WDATA     8'h0C
`define REG_STATUS    8'h10
`define REG_RDATA     8'h14
`define ST_BUSY       0
`define ST_WINDOW     1
`define ST_ERASING    2
`define ST_SUSPENDED  3
`define ST_REFUSED    4
`define ST_RERUN      5
`define SECTOR_RESET  6'h00
`define ADDR_RESET    21'h00_0000
`define WDATA_RESET   16'h0000

// ----------------------------------------------------------------
// operation codes written to the command register
// ----------------------------------------------------------------
`define OP_ERASE      4'h1
`define OP_ADD        4'h2
`define OP_SUSPEND    4'h3
`define OP_RESUME     4'h4
`define OP_READ       4'h5
`define OP_PROGRAM    4'h6
`define OP_SOFT_RST   4'h7
`define OP_HW_RST     4'h8
`define OP_AUTOSEL    4'h9
`define OP_DONE       4'hA

// ----------------------------------------------------------------
// flash command addresses and codes
// ----------------------------------------------------------------
`define UNLOCK_A1     21'h00_0555
`define UNLOCK_A2     21'h00_02AA
`define UNLOCK_D1     16'h00AA
`define UNLOCK_D2     16'h0055
`define CODE_SETUP    16'h0080
`define CODE_SECTOR   16'h0030
`define CODE_SUSPEND  16'h00B0
`define CODE_RESUME   16'h0030
`define CODE_PROGRAM  16'h00A0
`define CODE_RESET    16'h00F0
`define CODE_AUTOSEL  16'h0090
`define SECTOR_LSB    15

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ       200
`define CLK_NS        5
`define WINDOW_US     50
`define ADD_LIMIT_US  40
`define SUSPEND_US    20
`define RST_LOW_NS    500
`define RST_REC_NS    50
`define T_SETUP_NS    10
`define T_PULSE_NS    40
`define T_HOLD_NS     20

`endif

// ==== src/flash_host_pkg.sv ====
package flash_host_pkg;
  typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_PULSE, CYC_HOLD} cyc_state_t;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_ISSUE, SEQ_SUSP_WAIT, SEQ_RST_LOW, SEQ_RST_REC
  } seq_state_t;
  typedef logic [3:0] op_t;
endpackage : flash_host_pkg

// ==== src/flash_bus_cycle.sv ====
`timescale 1ns/10ps
`include "flash_host_map.svh"

module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int SETUP_CYCLES = (`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int PULSE_CYCLES = (`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int HOLD_CYCLES  = (`T_HOLD_NS + `CLK_NS - 1) / `CLK_NS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [20:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic             done_out,
  output logic [15:0]      rdata_out,
  output logic [20:0]      flash_addr_out,
  output logic [15:0]      flash_dq_out,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_dq_oe_b_out,
  output logic             flash_ce_b_out,
  output logic             flash_we_b_out,
  output logic             flash_oe_b_out
);

  cyc_state_t state;
  logic [7:0] cnt;
  logic       is_wr;

  if (SETUP_CYCLES < 1 || PULSE_CYCLES < 1 || HOLD_CYCLES < 1 ||
      SETUP_CYCLES > 255 || PULSE_CYCLES > 255 || HOLD_CYCLES > 255) begin : g_chk
    $error("flash_bus_cycle: phase lengths must be 1..255");
  end

  // ----------------------------------------------------------------
  // one strobed cycle: setup, strobe low, hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= CYC_IDLE;
      cnt      <= 8'h00;
      is_wr    <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state)
        CYC_IDLE: if (req_in) begin
          state <= CYC_SETUP;
          is_wr <= wr_in;
          cnt   <= 8'(SETUP_CYCLES - 1);
        end
        CYC_SETUP: if (cnt == 8'h00) begin
          state <= CYC_PULSE;
          cnt   <= 8'(PULSE_CYCLES - 1);
        end else cnt <= cnt - 8'h01;
        CYC_PULSE: if (cnt == 8'h00) begin
          state <= CYC_HOLD;
          cnt   <= 8'(HOLD_CYCLES - 1);
        end else cnt <= cnt - 8'h01;
        CYC_HOLD: if (cnt == 8'h00) begin
          state    <= CYC_IDLE;
          done_out <= 1'b1;           // strobe already high: device timers run
        end else cnt <= cnt - 8'h01;
      endcase
    end
  end

  // address and data registered at request, held over the cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flash_addr_out <= 21'h00_0000;
      flash_dq_out   <= 16'h0000;
    end else if (state == CYC_IDLE && req_in) begin
      flash_addr_out <= addr_in;
      flash_dq_out   <= wdata_in;
    end
  end

  // read data captured at the last cycle of the output strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rdata_out <= 16'h0000;
    else if (state == CYC_PULSE && cnt == 8'h00 && !is_wr) rdata_out <= flash_dq_in;
  end

  // strobes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flash_ce_b_out    <= 1'b1;
      flash_we_b_out    <= 1'b1;
      flash_oe_b_out    <= 1'b1;
      flash_dq_oe_b_out <= 1'b1;
    end else begin
      flash_ce_b_out    <= !(state == CYC_IDLE ? req_in : !(state == CYC_HOLD && cnt == 8'h00));
      flash_we_b_out    <= !(is_wr && ((state == CYC_SETUP && cnt == 8'h00) ||
                                       (state == CYC_PULSE && cnt != 8'h00)));
      flash_oe_b_out    <= !(!is_wr && ((state == CYC_SETUP && cnt == 8'h00) ||
                                        (state == CYC_PULSE && cnt != 8'h00)));
      flash_dq_oe_b_out <= !(state == CYC_IDLE ? (req_in && wr_in) :
                             (is_wr && !(state == CYC_HOLD && cnt == 8'h00)));
    end
  end

endmodule : flash_bus_cycle

// ==== sim/sector_erase_host_assertions.sv ====
`timescale 1ns/10ps
module sector_erase_host_assertions (
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic       pready_out,
  input wire logic       pslverr_out,
  input wire logic       flash_dq_oe_b_out,
  input wire logic       flash_ce_b_out,
  input wire logic       flash_we_b_out,
  input wire logic       flash_oe_b_out,
  input wire logic       flash_reset_b_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----
  // bus and strobe relations
  // ----
  a_ready_high: assert property (psel_in && penable_in |-> pready_out)
    else $error("no ready");
  a_unmapped_err: assert property (
    psel_in && penable_in |-> pslverr_out ==
      !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14})) else $error("bad slverr");
  a_write_owned: assert property (
    !flash_we_b_out |-> !flash_ce_b_out && !flash_dq_oe_b_out) else $error("loose write");
  a_we_setup: assert property ($fell(flash_we_b_out) |-> !$past(flash_ce_b_out))
    else $error("no setup");
  a_we_width: assert property ($fell(flash_we_b_out) |-> !flash_we_b_out [*4])
    else $error("short strobe");
  a_read_free: assert property (!flash_oe_b_out |-> flash_dq_oe_b_out && flash_we_b_out)
    else $error("read clash");
  a_reset_len: assert property ($fell(flash_reset_b_out) |-> !flash_reset_b_out [*8])
    else $error("short reset");
  a_reset_quiet: assert property (!flash_reset_b_out |-> flash_ce_b_out)
    else $error("access in reset");
endmodule : sector_erase_host_assertions

bind sector_erase_host sector_erase_host_assertions u_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .flash_dq_oe_b_out(flash_dq_oe_b_out), .flash_ce_b_out(flash_ce_b_out),
  .flash_we_b_out(flash_we_b_out), .flash_oe_b_out(flash_oe_b_out),
  .flash_reset_b_out(flash_reset_b_out));

// ==== sim/flash_device_model.sv ====
`timescale 1ns/10ps
module flash_device_model #(
  parameter int WINDOW_CYCLES = 200
) (
  input  wire logic        clk_in,
  input  wire logic        reset_b_in,
  input  wire logic        ce_b_in,
  input  wire logic        we_b_in,
  input  wire logic        oe_b_in,
  input  wire logic        host_oe_b_in,
  input  wire logic [20:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out
);
  logic we_q = 1'b1, win = 1'b0, ers = 1'b0, sus = 1'b0;
  logic [2:0] step = 3'd0;
  logic [5:0] esec = 6'h00;
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  int tmr = 0;
  wire logic [7:0] code = dq_in[7:0];
  wire logic [10:0] low = addr_in[10:0];
  wire logic hit = ers && addr_in[20:15] == esec;
  // ----
  // command decode at the rising write strobe; erase runs on its own
  // ----
  always @(posedge clk_in) begin
    we_q <= we_b_in;
    if (!reset_b_in) begin
      {step, win, ers, sus} <= 6'h00;
    end else begin
      tmr <= tmr + 1;
      if (win && tmr >= WINDOW_CYCLES) win <= 1'b0;
      if (we_b_in && !we_q && !ce_b_in && !host_oe_b_in) begin
        if (win && code == 8'h30) tmr <= 0;
        else if ((win || ers && !sus) && code == 8'hB0) {sus, win} <= 2'b10;
        else if (win) {win, ers} <= 2'b00;
        else if (ers && !sus) step <= 3'd0;
        else if (sus && code == 8'h30) sus <= !hit;
        else case (step)
          3'd0, 3'd3: step <= (low == 11'h555 && code == 8'hAA) ? step + 3'd1 : 3'd0;
          3'd1, 3'd4: step <= (low == 11'h2AA && code == 8'h55) ? step + 3'd1 : 3'd0;
          3'd2: step <= code == 8'h80 ? 3'd3 : code == 8'hA0 ? 3'd6 : 3'd0;
          3'd5: begin
            step <= 3'd0;
            if (code == 8'h30) {ers, win, esec} <= {2'b11, addr_in[20:15]};
            tmr <= 0;
          end
          default: begin
            mem[addr_in[3:0]] <= dq_in;
            step <= 3'd0;
          end
        endcase
      end
    end
    if (!oe_b_in) last <= dq_out;
  end
  // status in the sector the erase command named, inverted stale data once released
  assign dq_out = oe_b_in ? ~last : hit ? {8'h00, sus, 7'h00} : mem[addr_in[3:0]];
endmodule : flash_device_model

// ==== sim/sector_erase_host_test.sv ====
`timescale 1ns/10ps
module sector_erase_host_test;
  logic clk_in = 1'b0, rst_b_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, err, ce_b, we_b, oe_b, dq_oe_b, fl_rst_b;
  logic [20:0] fa;
  logic [15:0] fdo, fdi;
  int mismatches = 0, checks = 0, cyc = 0;
  sector_erase_host #(.WINDOW_CYCLES(200), .ADD_LIMIT_CYCLES(150), .SUSPEND_CYCLES(20)) u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .flash_addr_out(fa), .flash_dq_out(fdo),
    .flash_dq_in(fdi), .flash_dq_oe_b_out(dq_oe_b), .flash_ce_b_out(ce_b),
    .flash_we_b_out(we_b), .flash_oe_b_out(oe_b), .flash_reset_b_out(fl_rst_b));
  flash_device_model #(.WINDOW_CYCLES(200)) u_flash (.clk_in(clk_in), .reset_b_in(fl_rst_b),
    .ce_b_in(ce_b), .we_b_in(we_b), .oe_b_in(oe_b), .host_oe_b_in(dq_oe_b), .addr_in(fa),
    .dq_in(fdo), .dq_out(fdi));
  // ----
  // clock, hang guard and shared tasks
  // ----
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      close_out;
    end
  end
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic idle;
    do apb(1'b0, 8'h10, 32'h0000_0000); while (q[0] !== 1'b0);
  endtask : idle
  task automatic op(input logic [3:0] c);
    apb(1'b1, 8'h00, {28'h000_0000, c});
    idle;
  endtask : op
  task automatic st(input logic [5:0] e);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({err, q}, {27'h000_0000, e});
  endtask : st
  task automatic rdv(input logic [31:0] e);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({1'b0, q}, {1'b0, e});
  endtask : rdv
  // ----
  // scenarios
  // ----
  task automatic t_program;
    st(6'h00);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({err, q}, 33'h1_0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0003);
    apb(1'b1, 8'h0C, 32'h0000_1234);
    op(4'h6);
    op(4'h5);
    rdv(32'h0000_1234);
  endtask : t_program
  task automatic t_suspend;
    apb(1'b1, 8'h04, 32'h0000_0005);
    op(4'h1);
    st(6'h06);
    apb(1'b1, 8'h04, 32'h0000_0009);
    op(4'h2);
    st(6'h06);
    op(4'h3);
    st(6'h0C);
    op(4'h5);
    rdv(32'h0000_1234);
    apb(1'b1, 8'h08, 32'h0002_8000);
    op(4'h5);
    rdv(32'h0000_0080);
    op(4'h9);
    op(4'h7);
    st(6'h0C);
    apb(1'b1, 8'h04, 32'h0000_0005);
    op(4'h4);
    st(6'h04);
    op(4'h4);
    st(6'h14);
    apb(1'b1, 8'h10, 32'h0000_0010);
    op(4'h6);
    st(6'h14);
    apb(1'b1, 8'h10, 32'h0000_0010);
    op(4'h3);
    st(6'h0C);
    op(4'h4);
    op(4'h8);
    st(6'h20);
    apb(1'b1, 8'h10, 32'h0000_0020);
  endtask : t_suspend
  task automatic t_window;
    op(4'h1);
    op(4'h6);
    st(6'h00);
    op(4'h1);
    repeat (250) @(posedge clk_in);
    st(6'h04);
    op(4'hA);
    st(6'h00);
  endtask : t_window
  task automatic close_out;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_program;
    t_suspend;
    t_window;
    close_out;
  end
endmodule : sector_erase_host_test
